/* File: src/sfps_seq.sv */
/*
 Program, erase, suspend and resume sequencer of a serial NOR flash.
 Decodes frames from the host pins, checks enables and protection,
 times the self-timed cycles and keeps busy, write latch and paused.
 Assumes select, serial clock and lanes are asynchronous pins, and the
 serial clock is at most a quarter of ref_clk_in.
// Notes on behaviour
// - Four-lane program: 32h, address, data, enables.
// - Program fills one 256-byte page only.
// - Four-lane program needs four-lane enable set.
// - 20h plus address clears one 4 KB sector.
// - 52h plus address clears one 32 KB block.
// - D8h plus address clears one 64 KB block.
// - C7h or 60h clears whole array.
// - Select must rise on byte boundary, else discard.
// - Busy high through self-timed cycle; status readable.
// - Write latch clears when cycle ends.
// - Protected targets skipped; chip erase if any.
// - Suspend only busy, not paused, pausable op.
// - Suspend ignored during whole-array erase.
// - Suspend sets paused now, busy drops later.
// - Reset clears paused; later resume ignored.
// - Resume only paused and idle; busy returns.
// - Program data wraps within its page.
*/
`timescale 1ns/100ps
`default_nettype none
module sfps_seq
    import sfps_pkg::*;
#(
    parameter int unsigned PROG_CYC  = 140000,
    parameter int unsigned SECT_CYC  = 9000000,
    parameter int unsigned BLK32_CYC = 24000000,
    parameter int unsigned BLK64_CYC = 30000000,
    parameter int unsigned CHIP_CYC  = 400000000,
    parameter int unsigned PAUSE_CYC = 4000
)(
    input  wire logic          ref_clk_in,
    input  wire logic          arst_n_in,
    input  wire logic          ce_in,
    input  wire logic          sel_n_in,
    input  wire logic          sclk_in,
    input  wire logic [3:0]    lane_in,
    input  wire logic [AW-1:0] reg_addr_in,
    input  wire logic [7:0]    reg_wdata_in,
    input  wire logic          reg_wr_in,
    input  wire logic          reg_rd_in,
    output logic      [7:0]    reg_rdata_out,
    output logic               busy_out,
    output logic               write_latch_out,
    output logic               paused_flag_out,
    output logic               op_start_out,
    output sfps_op_t           op_out,
    output logic               op_done_out,
    output logic               pgbuf_wr_out,
    output sfps_pgbyte_t       pgbuf_out
);

    typedef enum logic [1:0] {
        SFPS_IDLE    = 2'b00,
        SFPS_RUN     = 2'b01,
        SFPS_PAUSING = 2'b11,
        SFPS_PAUSED  = 2'b10
    } sfps_state_t;

    function automatic logic prot_hit(input logic [23:0] a,
                                      input logic [2:0]  bp,
                                      input logic        tb,
                                      input logic        sec,
                                      input logic        cmp);
        logic [31:0] size;
        logic [31:0] off;
        logic        hit;
        size = 32'h0;
        off  = 32'h0;
        hit  = 1'b0;
        if (bp != 3'h0)
        begin
            if (sec)
                size = SECT_BYTES << ((bp > SMALL_CAP ? SMALL_CAP : bp) - 3'h1);
            else
                size = BLK64_BYTES << (bp - 3'h1);
            off = tb ? {8'h00, a} : (ARR_BYTES - 32'h1 - {8'h00, a});
            hit = off < size;
        end
        return hit ^ cmp;
    endfunction

    logic [5:0] pin_s;
    logic       sel_n_s;
    logic       sclk_s;
    logic [3:0] lane_s;

    sfps_sync #(.W(6)) u_sync (
        .ref_clk_in (ref_clk_in),
        .arst_n_in  (arst_n_in),
        .ce_in      (ce_in),
        .d_in       ({sel_n_in, sclk_in, lane_in}),
        .q_out      (pin_s)
    );

    assign sel_n_s = pin_s[5];
    assign sclk_s  = pin_s[4];
    assign lane_s  = pin_s[3:0];

    sfps_state_t state_q;
    sfps_op_t    cur_q;
    logic        sel_n_d_q;
    logic        sclk_d_q;
    logic [5:0]  hdr_cnt_q;
    logic [31:0] shreg_q;
    logic [7:0]  byte_q;
    logic [3:0]  dat_cnt_q;
    logic        have_data_q;
    logic        over_q;
    logic [7:0]  page_idx_q;
    logic [31:0] timer_q;
    logic [31:0] pause_q;
    logic        wl_q;
    logic [2:0]  bp_q;
    logic        tb_q;
    logic        sec_q;
    logic        qe_q;
    logic        cmp_q;
    logic        sus_q;
    logic [7:0]  last_q;
    logic [7:0]  rdata_q;
    logic        start_q;
    logic        done_q;
    logic        pg_wr_q;
    sfps_pgbyte_t pg_q;

    wire        sclk_rise = sclk_s & ~sclk_d_q;
    wire        sel_fall  = ~sel_n_s & sel_n_d_q;
    wire        sel_rise  = sel_n_s & ~sel_n_d_q;
    wire        shift_en  = sclk_rise & ~sel_n_s;
    wire [7:0]  op8       = shreg_q[7:0];
    wire [7:0]  op32      = shreg_q[31:24];
    wire [23:0] addr24    = shreg_q[23:0];
    wire        in_hdr    = hdr_cnt_q < HDR_BITS;
    wire        is_prog1  = op32 == OPC_PROG_1;
    wire        is_prog4  = op32 == OPC_PROG_4;
    wire        is_prog   = is_prog1 | is_prog4;
    wire [3:0]  step      = is_prog4 ? STEP_QUAD : STEP_ONE;
    wire [7:0]  byte_nx   = is_prog4 ? {byte_q[3:0], lane_s} : {byte_q[6:0], lane_s[0]};
    wire [3:0]  dat_nx    = dat_cnt_q + step;
    wire        byte_done = dat_nx == BYTE_BITS;

    // A frame counts only when select rises right after a whole byte.
    wire frm_short = (hdr_cnt_q == OPC_BITS) & ~over_q;
    wire frm_addr  = (hdr_cnt_q == HDR_BITS) & ~over_q & ~have_data_q & (dat_cnt_q == 4'h0);
    wire frm_data  = (hdr_cnt_q == HDR_BITS) & have_data_q & (dat_cnt_q == 4'h0);

    wire is_chip   = frm_short & ((op8 == OPC_CHIP_A) | (op8 == OPC_CHIP_B));
    wire is_susp   = frm_short & (op8 == OPC_SUSPEND);
    wire is_res    = frm_short & (op8 == OPC_RESUME);
    wire is_sect   = frm_addr & (op32 == OPC_SECT);
    wire is_b32    = frm_addr & (op32 == OPC_BLK32);
    wire is_b64    = frm_addr & (op32 == OPC_BLK64);
    wire is_pp     = frm_data & (is_prog1 | (is_prog4 & qe_q));

    // Erase units are aligned down, so any address selects its region.
    wire [23:0] base_sect = addr24 & ~24'(SECT_BYTES - 1);
    wire [23:0] base_b32  = addr24 & ~24'(BLK32_BYTES - 1);
    wire [23:0] base_b64  = addr24 & ~24'(BLK64_BYTES - 1);
    wire [23:0] base_page = addr24 & ~24'(PAGE_BYTES - 1);

    sfps_kind_t  new_kind;
    logic [23:0] new_base;
    logic [23:0] new_last;
    logic [31:0] new_cyc;

    always_comb
    begin
        new_kind = SFPS_K_PROG;
        new_base = base_page;
        new_last = base_page | 24'(PAGE_BYTES - 1);
        new_cyc  = PROG_CYC;
        if (is_sect)
        begin
            new_kind = SFPS_K_SECT;
            new_base = base_sect;
            new_last = base_sect | 24'(SECT_BYTES - 1);
            new_cyc  = SECT_CYC;
        end
        else if (is_b32)
        begin
            new_kind = SFPS_K_BLK32;
            new_base = base_b32;
            new_last = base_b32 | 24'(BLK32_BYTES - 1);
            new_cyc  = BLK32_CYC;
        end
        else if (is_b64)
        begin
            new_kind = SFPS_K_BLK64;
            new_base = base_b64;
            new_last = base_b64 | 24'(BLK64_BYTES - 1);
            new_cyc  = BLK64_CYC;
        end
        else if (is_chip)
        begin
            new_kind = SFPS_K_CHIP;
            new_base = 24'h00_0000;
            new_last = 24'(ARR_BYTES - 1);
            new_cyc  = CHIP_CYC;
        end
    end

    // Both ends of the target are checked; the whole array is hit if any page is.
    wire any_prot = (bp_q != 3'h0) | cmp_q;
    wire tgt_prot = is_chip ? any_prot
                  : (prot_hit(new_base, bp_q, tb_q, sec_q, cmp_q)
                   | prot_hit(new_last, bp_q, tb_q, sec_q, cmp_q));

    wire want_op  = is_pp | is_sect | is_b32 | is_b64 | is_chip;
    wire go       = sel_rise & want_op & (state_q == SFPS_IDLE) & wl_q & ~tgt_prot;
    wire can_susp = (state_q == SFPS_RUN) & ~sus_q & (cur_q.kind != SFPS_K_CHIP);
    wire do_susp  = sel_rise & is_susp & can_susp;
    wire do_res   = sel_rise & is_res & (state_q == SFPS_PAUSED) & sus_q;
    wire run_end  = (state_q == SFPS_RUN) & (timer_q <= 32'h1);
    wire pause_end = (state_q == SFPS_PAUSING) & (pause_q <= 32'h1);

    // Host-side frame capture: opcode and address on lane zero, then data.
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            sel_n_d_q   <= 1'b1;
            sclk_d_q    <= 1'b0;
            hdr_cnt_q   <= 6'h00;
            shreg_q     <= 32'h0000_0000;
            byte_q      <= 8'h00;
            dat_cnt_q   <= 4'h0;
            have_data_q <= 1'b0;
            over_q      <= 1'b0;
            page_idx_q  <= 8'h00;
        end
        else if (ce_in)
        begin
            sel_n_d_q <= sel_n_s;
            sclk_d_q  <= sclk_s;
            if (sel_fall)
            begin
                hdr_cnt_q   <= 6'h00;
                dat_cnt_q   <= 4'h0;
                have_data_q <= 1'b0;
                over_q      <= 1'b0;
            end
            else if (shift_en && in_hdr)
            begin
                shreg_q   <= {shreg_q[30:0], lane_s[0]};
                hdr_cnt_q <= hdr_cnt_q + 6'h01;
                if (hdr_cnt_q == HDR_BITS - 6'h01)
                    page_idx_q <= {shreg_q[6:0], lane_s[0]};
            end
            else if (shift_en && is_prog)
            begin
                byte_q    <= byte_nx;
                dat_cnt_q <= byte_done ? 4'h0 : dat_nx;
                if (byte_done)
                begin
                    have_data_q <= 1'b1;
                    page_idx_q  <= page_idx_q + 8'h01;
                end
            end
            else if (shift_en)
                over_q <= 1'b1;
        end
    end

    // Each finished byte goes to the page latch; only a start commits it.
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pg_wr_q <= 1'b0;
            pg_q    <= '0;
        end
        else if (ce_in)
        begin
            pg_wr_q <= shift_en & ~in_hdr & is_prog & byte_done;
            if (shift_en && !in_hdr && is_prog && byte_done)
                pg_q <= '{idx: page_idx_q, data: byte_nx};
        end
    end

    // Self-timed cycle, suspend and resume.
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_q <= SFPS_IDLE;
            cur_q   <= '0;
            timer_q <= 32'h0000_0000;
            pause_q <= 32'h0000_0000;
            sus_q   <= 1'b0;
            start_q <= 1'b0;
            done_q  <= 1'b0;
            last_q  <= 8'h00;
        end
        else if (ce_in)
        begin
            start_q <= go;
            done_q  <= run_end;
            unique case (state_q)
                SFPS_IDLE:
                begin
                    if (go)
                    begin
                        state_q <= SFPS_RUN;
                        cur_q   <= '{kind: new_kind, addr: new_base};
                        timer_q <= new_cyc;
                        last_q  <= is_pp ? op32 : (is_chip ? op8 : op32);
                    end
                end
                SFPS_RUN:
                begin
                    if (do_susp)
                    begin
                        state_q <= SFPS_PAUSING;
                        sus_q   <= 1'b1;
                        pause_q <= PAUSE_CYC;
                    end
                    else if (run_end)
                        state_q <= SFPS_IDLE;
                    else
                        timer_q <= timer_q - 32'h1;
                end
                SFPS_PAUSING:
                begin
                    if (pause_end)
                        state_q <= SFPS_PAUSED;
                    else
                        pause_q <= pause_q - 32'h1;
                end
                SFPS_PAUSED:
                begin
                    if (do_res)
                    begin
                        state_q <= SFPS_RUN;
                        sus_q   <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Status bits written by software; refused unless the sequencer is idle.
    wire sw_wr  = reg_wr_in & (state_q == SFPS_IDLE);
    wire wr_s1  = sw_wr & (reg_addr_in == REG_STAT1);
    wire wr_s2  = sw_wr & (reg_addr_in == REG_STAT2);

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            wl_q  <= 1'b0;
            bp_q  <= 3'h0;
            tb_q  <= 1'b0;
            sec_q <= 1'b0;
            qe_q  <= 1'b0;
            cmp_q <= 1'b0;
        end
        else if (ce_in)
        begin
            if (run_end)
                wl_q <= 1'b0;
            else if (wr_s1)
                wl_q <= reg_wdata_in[S1_WL];
            if (wr_s1)
            begin
                bp_q  <= reg_wdata_in[S1_BP_H:S1_BP_L];
                tb_q  <= reg_wdata_in[S1_TB];
                sec_q <= reg_wdata_in[S1_SEC];
            end
            if (wr_s2)
            begin
                qe_q  <= reg_wdata_in[S2_QE];
                cmp_q <= reg_wdata_in[S2_CMP];
            end
        end
    end

    wire       busy = (state_q == SFPS_RUN) | (state_q == SFPS_PAUSING);
    wire [7:0] s1_v = {1'b0, sec_q, tb_q, bp_q, wl_q, busy};
    wire [7:0] s2_v = {sus_q, cmp_q, 4'h0, qe_q, 1'b0};
    wire [7:0] rd_v = (reg_addr_in == REG_STAT1) ? s1_v
                    : (reg_addr_in == REG_STAT2) ? s2_v
                    : (reg_addr_in == REG_LAST)  ? last_q
                    : STAT_RST;

    // Status stays readable in every state, the cycle included.
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rdata_q <= STAT_RST;
        else if (ce_in)
            rdata_q <= reg_rd_in ? rd_v : STAT_RST;
    end

    assign reg_rdata_out   = rdata_q;
    assign busy_out        = busy;
    assign write_latch_out = wl_q;
    assign paused_flag_out = sus_q;
    assign op_start_out    = start_q;
    assign op_out          = cur_q;
    assign op_done_out     = done_q;
    assign pgbuf_wr_out    = pg_wr_q;
    assign pgbuf_out       = pg_q;

endmodule
`default_nettype wire

/* File: common/sfps_pkg.sv */
/*
 Shared constants and types of the serial flash program, erase and
 suspend sequencer: opcodes, frame lengths, register map and fields.
 Assumes a 200 MHz core clock and a 1 MB array behind the sequencer.
*/
package sfps_pkg;

    localparam logic [7:0] OPC_PROG_1   = 8'h02;
    localparam logic [7:0] OPC_PROG_4   = 8'h32;
    localparam logic [7:0] OPC_SECT     = 8'h20;
    localparam logic [7:0] OPC_BLK32    = 8'h52;
    localparam logic [7:0] OPC_BLK64    = 8'hD8;
    localparam logic [7:0] OPC_CHIP_A   = 8'hC7;
    localparam logic [7:0] OPC_CHIP_B   = 8'h60;
    localparam logic [7:0] OPC_SUSPEND  = 8'h75;
    localparam logic [7:0] OPC_RESUME   = 8'h7A;

    localparam logic [5:0] OPC_BITS     = 6'd8;
    localparam logic [5:0] HDR_BITS     = 6'd32;
    localparam logic [3:0] BYTE_BITS    = 4'd8;
    localparam logic [3:0] STEP_ONE     = 4'd1;
    localparam logic [3:0] STEP_QUAD    = 4'd4;

    localparam int unsigned ARR_BYTES   = 32'h0010_0000;
    localparam int unsigned SECT_BYTES  = 32'h0000_1000;
    localparam int unsigned BLK32_BYTES = 32'h0000_8000;
    localparam int unsigned BLK64_BYTES = 32'h0001_0000;
    localparam int unsigned PAGE_BYTES  = 32'h0000_0100;
    localparam logic [2:0]  SMALL_CAP   = 3'h3;

    localparam int AW = 4;
    localparam logic [AW-1:0] REG_STAT1 = 4'h0;
    localparam logic [AW-1:0] REG_STAT2 = 4'h1;
    localparam logic [AW-1:0] REG_LAST  = 4'h2;

    localparam int S1_BUSY = 0;
    localparam int S1_WL   = 1;
    localparam int S1_BP_L = 2;
    localparam int S1_BP_H = 4;
    localparam int S1_TB   = 5;
    localparam int S1_SEC  = 6;
    localparam int S2_QE   = 1;
    localparam int S2_CMP  = 6;
    localparam int S2_SUS  = 7;
    localparam logic [7:0] STAT_RST = 8'h00;

    typedef enum logic [2:0] {
        SFPS_K_PROG  = 3'h0,
        SFPS_K_SECT  = 3'h1,
        SFPS_K_BLK32 = 3'h2,
        SFPS_K_BLK64 = 3'h3,
        SFPS_K_CHIP  = 3'h4
    } sfps_kind_t;

    typedef struct packed {
        sfps_kind_t  kind;
        logic [23:0] addr;
    } sfps_op_t;

    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] data;
    } sfps_pgbyte_t;

endpackage

/* File: src/sfps_sync.sv */
/*
 Two flip-flop synchroniser for a group of pin levels.
 Assumes the inputs are asynchronous to ref_clk_in and each bit is a level.
*/
`timescale 1ns/100ps
`default_nettype none
module sfps_sync
    import sfps_pkg::*;
#(
    parameter int W = 1
)(
    input  wire logic         ref_clk_in,
    input  wire logic         arst_n_in,
    input  wire logic         ce_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else if (ce_in)
        begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

    assign q_out = sync_q;

endmodule
`default_nettype wire

/* File: verification/sfps_seq_sva.sv */
/*
 Checker of the sequencer's status flags, pulses and read port.
 Assumes one clock domain and a running clock enable.
*/
`timescale 1ns/100ps
`default_nettype none
module sfps_seq_chk
    import sfps_pkg::*;
#(
    parameter int unsigned PAUSE_CYC = 4000
)(
    input wire logic       ref_clk_in,
    input wire logic       arst_n_in,
    input wire logic       ce_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       busy_out,
    input wire logic       write_latch_out,
    input wire logic       paused_flag_out,
    input wire logic       op_start_out,
    input wire sfps_op_t   op_out,
    input wire logic       op_done_out
);
    localparam int PZ_MAX = PAUSE_CYC + 3;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    AST_RDATA_IDLE: assert property ((ce_in && !reg_rd_in) |=> reg_rdata_out == 8'h00)
        else $error("read data not zero outside read");
    AST_START_OK: assert property (op_start_out |-> busy_out && write_latch_out)
        else $error("start without busy or write latch");
    AST_DONE: assert property (op_done_out |-> !busy_out && ($past(busy_out) || $past(busy_out, 2)))
        else $error("done pulse without busy fall");
    AST_WL_CLEAR: assert property (($fell(busy_out) && !paused_flag_out) |-> !write_latch_out)
        else $error("write latch kept after cycle end");
    AST_PAUSE_DROP: assert property ($rose(paused_flag_out) |-> busy_out ##[1:PZ_MAX] !busy_out)
        else $error("busy not dropped within pause latency");
    AST_PAUSE_COND: assert property ($rose(paused_flag_out) |-> $past(busy_out) && op_out.kind != SFPS_K_CHIP)
        else $error("suspend taken in wrong state");
    AST_RESUME: assert property ($fell(paused_flag_out) |-> busy_out)
        else $error("busy not back on resume");
    AST_BASE: assert property ((op_start_out && op_out.kind == SFPS_K_SECT) |-> op_out.addr[11:0] == 12'h000)
        else $error("sector base not aligned");
endmodule

bind sfps_seq sfps_seq_chk #(.PAUSE_CYC(PAUSE_CYC)) u_chk (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .busy_out(busy_out), .write_latch_out(write_latch_out),
    .paused_flag_out(paused_flag_out), .op_start_out(op_start_out), .op_out(op_out), .op_done_out(op_done_out));
`default_nettype wire

/* File: verification/sfps_host.sv */
/*
 Host controller model driving select, serial clock and lanes.
 Assumes the bench loads program bytes into dq before a frame.
*/
`timescale 1ns/100ps
`default_nettype none
module sfps_host (
    output logic       sel_n_out,
    output logic       sclk_out,
    output logic [3:0] lane_out
);
    logic [7:0] dq[$];

    initial
    begin
        sel_n_out = 1'b1;
        sclk_out  = 1'b0;
        lane_out  = 4'h5;
    end

    // A negative trim drops clocks at the end, a positive one adds them.
    task automatic frame(input logic [7:0] opc, input logic [23:0] adr, input bit wa, input bit quad,
                         input int trim);
        logic [3:0] v[$];
        for (int i = 7; i >= 0; i--)
            v.push_back({3'b000, opc[i]});
        for (int i = 23; i >= 0; i--)
            if (wa)
                v.push_back({3'b000, adr[i]});
        foreach (dq[k])
            for (int i = 7; i >= 0; i -= (quad ? 4 : 1))
                v.push_back(quad ? dq[k][i -: 4] : {3'b000, dq[k][i]});
        for (int i = 0; i < -trim; i++)
            void'(v.pop_back());
        for (int i = 0; i < trim; i++)
            v.push_back(4'h0);
        dq.delete();
        sel_n_out = 1'b0;
        foreach (v[k])
        begin
            lane_out = v[k];
            #40 sclk_out = 1'b1;
            #40 sclk_out = 1'b0;
        end
        #40 sel_n_out = 1'b1;
        // Released lanes show the inverse so no stale value is read.
        lane_out = ~lane_out;
        #200;
    endtask
endmodule
`default_nettype wire

/* File: verification/test_sfps_seq.sv */
/*
 Self-checking bench of the program, erase and suspend sequencer.
 Assumes shortened cycle lengths and the host model on the pins.
*/
`timescale 1ns/100ps
`default_nettype none
module test_sfps_seq;
    import sfps_pkg::*;
    localparam int PZ = 20;
    localparam logic [7:0]  OC[5] = '{OPC_SECT, OPC_BLK32, OPC_BLK64, OPC_CHIP_A, OPC_CHIP_B};
    localparam logic [2:0]  KD[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h4};
    localparam logic [23:0] MK[5] = '{24'hFF_F000, 24'hFF_8000, 24'hFF_0000, 24'h00_0000, 24'h00_0000};
    logic          ref_clk_in   = 1'b0;
    logic          arst_n_in    = 1'b0;
    logic [AW-1:0] reg_addr_in  = '0;
    logic [7:0]    reg_wdata_in = '0;
    logic          reg_wr_in    = 1'b0;
    logic          reg_rd_in    = 1'b0;
    logic          rd_q         = 1'b0;
    logic          ce           = 1'b1;
    logic [31:0]   rs           = 32'h3ff8_5ac4;
    logic          sel_n, sclk, busy_out, wl, pf, op_start, op_done, pg_wr;
    logic [3:0]    lane;
    logic [7:0]    rdata;
    sfps_op_t      op;
    sfps_pgbyte_t  pg;
    int            bad_count = 0;
    int            n_checks  = 0;
    int            cyc       = 0;
    logic [26:0]   eop[$];
    logic [15:0]   epg[$];
    logic [7:0]    erd[$];

    always #2.5 ref_clk_in = ~ref_clk_in;

    sfps_host host (.sel_n_out(sel_n), .sclk_out(sclk), .lane_out(lane));
    sfps_seq #(.PROG_CYC(50), .SECT_CYC(80), .BLK32_CYC(100), .BLK64_CYC(1500), .CHIP_CYC(1500),
               .PAUSE_CYC(PZ)) uut (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .ce_in(ce), .sel_n_in(sel_n), .sclk_in(sclk),
        .lane_in(lane), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata), .busy_out(busy_out), .write_latch_out(wl),
        .paused_flag_out(pf), .op_start_out(op_start), .op_out(op), .op_done_out(op_done),
        .pgbuf_wr_out(pg_wr), .pgbuf_out(pg));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (e !== s)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [AW-1:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= w;
        reg_rd_in    <= !w;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic [7:0] e);
        erd.push_back(e);
        bus(1'b0, a, e);
    endtask

    task automatic load(input logic [7:0] ix, input int n);
        repeat (n)
        begin
            rs = lfsr(rs);
            host.dq.push_back(rs[7:0]);
            epg.push_back({ix, rs[7:0]});
            ix++;
        end
    endtask

    task automatic settle(input int n);
        for (int i = 0; i < n && busy_out !== 1'b0; i++)
            @(posedge ref_clk_in);
    endtask

    always @(posedge ref_clk_in)
    begin
        rd_q <= reg_rd_in;
        cyc  <= cyc + 1;
        if (cyc == 40000)
        begin
            bad_count++;
            summarize();
        end
    end

    always @(negedge ref_clk_in)
    begin
        if (rd_q)
            cmp("rdata", erd.size() ? erd.pop_front() : 'x, rdata);
        if (op_start === 1'b1)
            cmp("op", eop.size() ? eop.pop_front() : 'x, op);
        if (pg_wr === 1'b1)
            cmp("pgbyte", epg.size() ? epg.pop_front() : 'x, pg);
    end

    initial
    begin
        logic [23:0] a;
        repeat (8) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        rd(REG_STAT1, STAT_RST);
        rd(REG_STAT2, STAT_RST);
        host.frame(OPC_SECT, 24'h00_1000, 1, 0, 0);
        cmp("busy", 1'b0, busy_out);
        bus(1'b1, REG_STAT1, 8'h02);
        a = 24'h01_23FE;
        load(a[7:0], 2);
        host.frame(OPC_PROG_4, a, 1, 1, 0);
        cmp("busy", 1'b0, busy_out);
        host.frame(OPC_CHIP_A, a, 0, 0, -1);
        host.frame(OPC_SECT, a, 1, 0, 1);
        cmp("busy", 1'b0, busy_out);
        bus(1'b1, REG_STAT2, 8'h02);
        load(a[7:0], 3);
        eop.push_back({SFPS_K_PROG, a[23:8], 8'h00});
        host.frame(OPC_PROG_4, a, 1, 1, 0);
        cmp("busy", 1'b1, busy_out);
        // A frozen clock enable must also freeze the cycle timer.
        @(posedge ref_clk_in);
        ce <= 1'b0;
        repeat (60) @(posedge ref_clk_in);
        ce <= 1'b1;
        cmp("busy", 1'b1, busy_out);
        rd(REG_STAT1, 8'h03);
        settle(300);
        rd(REG_STAT1, 8'h00);
        bus(1'b1, REG_STAT1, 8'h02);
        load(8'h10, 1);
        eop.push_back({SFPS_K_PROG, 24'h00_0100});
        host.frame(OPC_PROG_1, 24'h00_0110, 1, 0, 0);
        settle(300);
        for (int k = 0; k < 5; k++)
        begin
            rs = lfsr(rs);
            a = rs[23:0] & 24'h0F_FFFF;
            bus(1'b1, REG_STAT1, 8'h02);
            eop.push_back({KD[k], a & MK[k]});
            host.frame(OC[k], a, k < 3, 0, 0);
            cmp("busy", 1'b1, busy_out);
            settle(2500);
            cmp("latch", 1'b0, wl);
        end
        bus(1'b1, REG_STAT1, 8'h06);
        host.frame(OPC_SECT, 24'h0F_8000, 1, 0, 0);
        host.frame(OPC_CHIP_B, a, 0, 0, 0);
        rd(REG_STAT1, 8'h06);
        eop.push_back({SFPS_K_BLK64, 24'h02_0000});
        host.frame(OPC_BLK64, 24'h02_1234, 1, 0, 0);
        host.frame(OPC_SUSPEND, a, 0, 0, 0);
        cmp("paused", 1'b1, pf);
        host.frame(OPC_SUSPEND, a, 0, 0, 0);
        rd(REG_STAT2, 8'h82);
        rd(REG_STAT1, 8'h06);
        // No erase or status write is sent while paused.
        host.frame(OPC_RESUME, a, 0, 0, 0);
        cmp("busy", 1'b1, busy_out);
        cmp("paused", 1'b0, pf);
        repeat (PZ) @(posedge ref_clk_in);
        settle(2500);
        bus(1'b1, REG_STAT1, 8'h02);
        eop.push_back({SFPS_K_CHIP, 24'h00_0000});
        host.frame(OPC_CHIP_A, a, 0, 0, 0);
        host.frame(OPC_SUSPEND, a, 0, 0, 0);
        cmp("paused", 1'b0, pf);
        settle(2500);
        host.frame(OPC_RESUME, a, 0, 0, 0);
        cmp("busy", 1'b0, busy_out);
        bus(1'b1, REG_STAT1, 8'h02);
        eop.push_back({SFPS_K_BLK64, 24'h03_0000});
        host.frame(OPC_BLK64, 24'h03_0000, 1, 0, 0);
        host.frame(OPC_SUSPEND, a, 0, 0, 0);
        @(posedge ref_clk_in);
        arst_n_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        cmp("paused", 1'b0, pf);
        host.frame(OPC_RESUME, a, 0, 0, 0);
        cmp("busy", 1'b0, busy_out);
        cmp("ops left", 32'h0, eop.size());
        summarize();
    end
endmodule
`default_nettype wire
